// [rtl/lcd_cmd_decoder.sv]
// command decoder and extended mode register of a low-power ddr dram
// assumes: pins sampled on rising ref_clk, controller keeps its own timing rules
// Notes on behaviour
// - mode register set with bank bits 10 loads the address op-code into extended register
// - extended register holds its value until the next extended write
// - controller drives a7..a12 zero; device ignores a3 and a4
// - bits 6:5 select full, half or quarter drive; 11 reserved
// - bits 4:3 ignored; on-die sensor sets self-refresh period
// - bits 2:0 pick refreshed area: all, two banks, bank 0, half, quarter
// - self refresh covers only the selected area, all banks by default
// - chip select high or nop pattern both mean no operation
// - ras low alone activates a row: bank bits and a0..a12 row
// - cas low reads or writes: a0..a9 column, a10 auto precharge
// - we low alone is burst stop with cke high, deep power-down with cke low
// - ras and we low precharge one bank, or all when a10 high
// - ras and cas low refresh: auto with cke high, self with cke low
// - refresh commands ignore address, bank and data lines
// - mode set bank bits 00 base, 10 extended, others reserved
// - write data element stored only when its byte mask is low
// - all command and address pins sampled on the rising clock edge
// - nop and deselect start nothing and leave running work alone
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decoder
   import lcd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic memClkEn,
   input wire logic chipSelN,
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeEnN,
   input wire logic [BANK_W-1:0] bankAddr,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic writeByteMask,
   output logic [10:0] cmdCode,
   output logic cmdValid,
   output logic [BANK_W-1:0] cmdBank,
   output logic [ADDR_W-1:0] rowAddr,
   output logic [COL_W-1:0] colAddr,
   output logic autoPrecharge,
   output logic prechargeAll,
   output logic writeElemEn,
   output logic baseModeLoad,
   output logic [ADDR_W-1:0] baseOpCode,
   output logic [1:0] outputDriveLevel,
   output logic driveReserved,
   output logic [2:0] partialRefreshArea,
   output logic areaReserved,
   output logic [3:0] refreshBankMask,
   output logic [1:0] refreshFraction,
   output logic selfRefreshActive,
   output logic deepPowerDown,
   output logic cmdTooSoon
);
   // ----------------------------------------
   // command decode
   // ----------------------------------------
   lcd_cmd_t cmdNext;
   logic [12:0] extModeReg;
   logic [1:0] mrdCntReg;
   logic [3:0] bankMaskNext;
   logic [1:0] fracNext;

   always_comb begin
      unique case ({chipSelN, rowStrobeN, colStrobeN, writeEnN})
         4'h3: cmdNext = CMD_ACT;
         4'h5: cmdNext = CMD_READ;
         4'h4: cmdNext = CMD_WRITE;
         4'h6: cmdNext = memClkEn ? CMD_STOP : CMD_DPD;
         4'h2: cmdNext = CMD_PRE;
         4'h1: cmdNext = memClkEn ? CMD_AREF : CMD_SREF;
         4'h0: cmdNext = CMD_MRS;
         default: cmdNext = CMD_NOP;
      endcase
      if (!chipSelN && !rowStrobeN && !colStrobeN && !writeEnN
          && bankAddr != MRS_SEL_BASE && bankAddr != MRS_SEL_EXT) begin
         cmdNext = CMD_BAD;
      end
   end

   // decoded command registered once per rising edge; nop leaves address outputs and mode registers alone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmdCode <= CMD_NOP;
         cmdValid <= 1'b0;
      end else if (clkEn) begin
         cmdCode <= cmdNext;
         cmdValid <= (cmdNext != CMD_NOP);
      end
   end

   // address capture per command; refresh leaves the captured address untouched
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmdBank <= 2'h0;
         rowAddr <= 13'h0000;
         colAddr <= 10'h000;
         autoPrecharge <= 1'b0;
         prechargeAll <= 1'b0;
      end else if (clkEn) begin
         unique case (cmdNext)
            CMD_ACT: begin
               cmdBank <= bankAddr;
               rowAddr <= addr;
            end
            CMD_READ, CMD_WRITE: begin
               cmdBank <= bankAddr;
               colAddr <= addr[COL_W-1:0];
               autoPrecharge <= addr[AP_BIT];
            end
            CMD_PRE: begin
               prechargeAll <= addr[AP_BIT];
               cmdBank <= addr[AP_BIT] ? 2'h0 : bankAddr;
            end
            default: begin
               // refresh, mode set and nop take nothing from address lines here
            end
         endcase
      end
   end

   // ----------------------------------------
   // write mask
   // ----------------------------------------
   // one element per cycle here; the strobe datapath lives elsewhere
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         writeElemEn <= 1'b0;
      end else if (clkEn) begin
         writeElemEn <= !writeByteMask;
      end
   end

   // ----------------------------------------
   // mode registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         extModeReg <= EXT_MODE_RESET;
         baseModeLoad <= 1'b0;
         baseOpCode <= 13'h0000;
      end else if (clkEn) begin
         baseModeLoad <= 1'b0;
         if (cmdNext == CMD_MRS && bankAddr == MRS_SEL_EXT) begin
            extModeReg <= addr;
         end
         if (cmdNext == CMD_MRS && bankAddr == MRS_SEL_BASE) begin
            baseModeLoad <= 1'b1;
            baseOpCode <= addr;
         end
      end
   end

   // temp bits 4:3 and upper zero bits are stored but drive nothing
   always_comb begin
      outputDriveLevel = extModeReg[DRIVE_MSB:DRIVE_LSB];
      driveReserved = (extModeReg[DRIVE_MSB:DRIVE_LSB] == 2'h3);
      partialRefreshArea = extModeReg[AREA_MSB:AREA_LSB];
   end

   always_comb begin
      areaReserved = 1'b0;
      bankMaskNext = MASK_ALL;
      fracNext = FRAC_FULL;
      unique case (extModeReg[AREA_MSB:AREA_LSB])
         AREA_ALL: bankMaskNext = MASK_ALL;
         AREA_HALF: bankMaskNext = MASK_LOW_BANKS;
         AREA_BANK0: bankMaskNext = MASK_BANK0;
         AREA_HALF_BANK0: begin
            bankMaskNext = MASK_BANK0;
            fracNext = FRAC_HALF;
         end
         AREA_QUARTER_BANK0: begin
            bankMaskNext = MASK_BANK0;
            fracNext = FRAC_QUARTER;
         end
         default: areaReserved = 1'b1;
      endcase
   end

   // ----------------------------------------
   // power states
   // ----------------------------------------
   // exit is taken as cke going high again; exit timing is outside this block
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         selfRefreshActive <= 1'b0;
         deepPowerDown <= 1'b0;
      end else if (clkEn) begin
         if (cmdNext == CMD_SREF) begin
            selfRefreshActive <= 1'b1;
         end else if (memClkEn) begin
            selfRefreshActive <= 1'b0;
         end
         if (cmdNext == CMD_DPD) begin
            deepPowerDown <= 1'b1;
         end else if (memClkEn) begin
            deepPowerDown <= 1'b0;
         end
      end
   end

   // refresh area shown only while self refresh runs, full array otherwise
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         refreshBankMask <= MASK_ALL;
         refreshFraction <= FRAC_FULL;
      end else if (clkEn) begin
         refreshBankMask <= (cmdNext == CMD_SREF || (selfRefreshActive && !memClkEn))
                            ? bankMaskNext : MASK_ALL;
         refreshFraction <= (cmdNext == CMD_SREF || (selfRefreshActive && !memClkEn))
                            ? fracNext : FRAC_FULL;
      end
   end

   // ----------------------------------------
   // mode-set spacing monitor
   // ----------------------------------------
   // flags a controller slip; the device itself does not refuse the command
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mrdCntReg <= 2'h0;
         cmdTooSoon <= 1'b0;
      end else if (clkEn) begin
         cmdTooSoon <= (mrdCntReg != 2'h0) && (cmdNext != CMD_NOP);
         // reserved mode sets count too: the controller still owes the gap
         if (cmdNext == CMD_MRS || cmdNext == CMD_BAD) begin
            mrdCntReg <= 2'(MRD_CYCLES - 1);
         end else if (mrdCntReg != 2'h0) begin
            mrdCntReg <= mrdCntReg - 2'h1;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_ext_load: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_MRS && bankAddr == MRS_SEL_EXT
      |=> partialRefreshArea == $past(addr[2:0]) && outputDriveLevel == $past(addr[6:5]))
      else $error("extended register not loaded");
   chk_ext_hold: assert property (@(posedge ref_clk) disable iff (rst)
      !(cmdNext == CMD_MRS && bankAddr == MRS_SEL_EXT && clkEn)
      |=> $stable(outputDriveLevel) && $stable(partialRefreshArea))
      else $error("extended register changed without write");
   chk_drive_res: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_MRS && bankAddr == MRS_SEL_EXT
      |=> driveReserved == ($past(addr[6:5]) == 2'h3))
      else $error("drive reserved flag wrong");
   chk_sref_area: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_SREF && extModeReg[2:0] == AREA_BANK0
      |=> refreshBankMask == MASK_BANK0 && selfRefreshActive)
      else $error("self refresh area wrong");
   chk_nop_idle: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && chipSelN |=> !cmdValid && cmdCode == CMD_NOP)
      else $error("deselect produced a command");
   chk_act_row: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_ACT |=> rowAddr == $past(addr) && cmdBank == $past(bankAddr))
      else $error("activate row wrong");
   chk_read_ap: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_READ |=> autoPrecharge == $past(addr[10]) && cmdCode == CMD_READ)
      else $error("read decode wrong");
   chk_pre_all: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_PRE && addr[10] |=> prechargeAll)
      else $error("precharge all missed");
   chk_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && writeByteMask |=> !writeElemEn)
      else $error("masked element written");
   chk_mrd_gap: assert property (@(posedge ref_clk) disable iff (rst)
      (clkEn && cmdNext == CMD_MRS) ##1 (clkEn && cmdNext == CMD_ACT) |=> cmdTooSoon)
      else $error("early command not flagged");

   // ----------------------------------------
   // pin-level checks
   // ----------------------------------------
   // raw pins, not cmdNext (except chk_soon_clear), so a slip in the decode table cannot hide behind itself
   logic [3:0] cmdPins;
   assign cmdPins = {chipSelN, rowStrobeN, colStrobeN, writeEnN};
   chk_pin_act: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h3 |=> cmdCode == CMD_ACT && cmdValid)
      else $error("activate pins not decoded");
   chk_pin_read: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h5
      |=> cmdCode == CMD_READ && colAddr == $past(addr[9:0]) && cmdBank == $past(bankAddr))
      else $error("read pins not decoded");
   chk_pin_write: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h4
      |=> cmdCode == CMD_WRITE && colAddr == $past(addr[9:0]) && autoPrecharge == $past(addr[10]))
      else $error("write pins not decoded");
   chk_pin_stop: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h6 && memClkEn |=> cmdCode == CMD_STOP && !deepPowerDown)
      else $error("burst stop not decoded");
   chk_pin_dpd: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h6 && !memClkEn |=> cmdCode == CMD_DPD && deepPowerDown)
      else $error("deep power-down not entered");
   chk_pin_pre: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h2 && !addr[10]
      |=> cmdCode == CMD_PRE && !prechargeAll && cmdBank == $past(bankAddr))
      else $error("single bank precharge wrong");
   chk_pin_aref: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h1 && memClkEn
      |=> cmdCode == CMD_AREF && !selfRefreshActive && $stable(rowAddr) && $stable(cmdBank))
      else $error("auto refresh wrong");
   chk_pin_sref: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h1 && !memClkEn
      |=> cmdCode == CMD_SREF && selfRefreshActive && $stable(rowAddr) && $stable(cmdBank))
      else $error("self refresh entry wrong");
   chk_sref_quarter: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h1 && !memClkEn && partialRefreshArea == AREA_QUARTER_BANK0
      |=> refreshBankMask == MASK_BANK0 && refreshFraction == FRAC_QUARTER)
      else $error("quarter bank area wrong");
   chk_bad_mode: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h0 && bankAddr[0]
      |=> cmdCode == CMD_BAD && !baseModeLoad && $stable(outputDriveLevel) && $stable(partialRefreshArea))
      else $error("reserved mode set loaded");
   chk_base_load: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h0 && bankAddr == MRS_SEL_BASE |=> baseModeLoad && baseOpCode == $past(addr))
      else $error("base op-code not captured");
   chk_nop_pattern: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdPins == 4'h7 |=> !cmdValid && cmdCode == CMD_NOP)
      else $error("nop produced a command");
   chk_cmd_valid: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && !chipSelN && cmdPins != 4'h7 |=> cmdValid)
      else $error("command not marked valid");
   chk_power_exit: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && memClkEn
      |=> !selfRefreshActive && !deepPowerDown && refreshBankMask == MASK_ALL && refreshFraction == FRAC_FULL)
      else $error("power state kept with cke high");
   chk_elem_en: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && !writeByteMask |=> writeElemEn)
      else $error("unmasked element dropped");
   chk_soon_clear: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_NOP |=> !cmdTooSoon)
      else $error("nop flagged as early");

   cov_ext_write: cover property (@(posedge ref_clk) disable iff (rst)
      clkEn && cmdNext == CMD_MRS && bankAddr == MRS_SEL_EXT);
   cov_self_ref: cover property (@(posedge ref_clk) disable iff (rst) selfRefreshActive);
   cov_act_read: cover property (@(posedge ref_clk) disable iff (rst)
      cmdCode == CMD_ACT ##[1:4] cmdCode == CMD_READ);
   cov_deep_pd: cover property (@(posedge ref_clk) disable iff (rst) deepPowerDown);
   cov_bad_mode: cover property (@(posedge ref_clk) disable iff (rst) cmdCode == CMD_BAD);
endmodule : lcd_cmd_decoder
`default_nettype wire

// [rtl/lcd_pkg.sv]
// package of constants for the low-power dram command decoder and extended mode register
// assumes: one 40 MHz clock domain, command pins already synchronous to it
package lcd_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ADDR_W = 13;
   localparam int BANK_W = 2;
   localparam int COL_W = 10;
   // ----------------------------------------
   // bank select codes for mode register set
   // ----------------------------------------
   localparam logic [1:0] MRS_SEL_BASE = 2'h0;
   localparam logic [1:0] MRS_SEL_EXT = 2'h2;
   // ----------------------------------------
   // extended mode register fields
   // ----------------------------------------
   localparam int AREA_LSB = 0;
   localparam int AREA_MSB = 2;
   localparam int TEMP_LSB = 3;
   localparam int TEMP_MSB = 4;
   localparam int DRIVE_LSB = 5;
   localparam int DRIVE_MSB = 6;
   localparam int ZERO_LSB = 7;
   localparam int ZERO_MSB = 12;
   localparam int AP_BIT = 10;
   localparam logic [12:0] EXT_MODE_RESET = 13'h0000;
   // ----------------------------------------
   // field encodings
   // ----------------------------------------
   localparam logic [1:0] DRIVE_FULL = 2'h0;
   localparam logic [1:0] DRIVE_HALF = 2'h1;
   localparam logic [1:0] DRIVE_QUARTER = 2'h2;
   localparam logic [2:0] AREA_ALL = 3'h0;
   localparam logic [2:0] AREA_HALF = 3'h1;
   localparam logic [2:0] AREA_BANK0 = 3'h2;
   localparam logic [2:0] AREA_HALF_BANK0 = 3'h5;
   localparam logic [2:0] AREA_QUARTER_BANK0 = 3'h6;
   // one bit per bank plus array fraction of bank zero
   localparam logic [3:0] MASK_ALL = 4'hf;
   localparam logic [3:0] MASK_LOW_BANKS = 4'h3;
   localparam logic [3:0] MASK_BANK0 = 4'h1;
   localparam logic [1:0] FRAC_FULL = 2'h0;
   localparam logic [1:0] FRAC_HALF = 2'h1;
   localparam logic [1:0] FRAC_QUARTER = 2'h2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int MRD_CYCLES = 2;
   // ----------------------------------------
   // decoded commands
   // ----------------------------------------
   typedef enum logic [10:0] {
      CMD_NOP = 11'h001,
      CMD_ACT = 11'h002,
      CMD_READ = 11'h004,
      CMD_WRITE = 11'h008,
      CMD_STOP = 11'h010,
      CMD_DPD = 11'h020,
      CMD_PRE = 11'h040,
      CMD_AREF = 11'h080,
      CMD_SREF = 11'h100,
      CMD_MRS = 11'h200,
      CMD_BAD = 11'h400
   } lcd_cmd_t;
endpackage : lcd_pkg

// [verif/lcd_ctrl_model.sv]
// memory controller model: drives command, address and mask pins of the decoder
// assumes: tasks are entered on or after a rising ref_clk edge, one caller at a time
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_model
   import lcd_pkg::*;
(
   input wire logic ref_clk,
   output logic memClkEn,
   output logic chipSelN,
   output logic rowStrobeN,
   output logic colStrobeN,
   output logic writeEnN,
   output logic [BANK_W-1:0] bankAddr,
   output logic [ADDR_W-1:0] addr,
   output logic writeByteMask
);
   initial begin
      {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'hf;
      memClkEn = 1'b1;
      bankAddr = 2'h0;
      addr = 13'h0000;
      writeByteMask = 1'b1;
   end

   // pins order: chip select, row strobe, column strobe, write enable
   task automatic drive(input logic [3:0] pins, input logic cke, input logic [1:0] ba, input logic [12:0] a);
      @(posedge ref_clk);
      {chipSelN, rowStrobeN, colStrobeN, writeEnN} <= pins;
      memClkEn <= cke;
      bankAddr <= ba;
      addr <= a;
   endtask : drive

   // one deselect cycle after every command keeps mode sets two cycles apart
   task automatic idle();
      @(posedge ref_clk);
      {chipSelN, rowStrobeN, colStrobeN, writeEnN} <= 4'hf;
      memClkEn <= 1'b1;
      // stale address must never look meaningful while deselected
      bankAddr <= ~bankAddr;
      addr <= ~addr;
   endtask : idle

   task automatic ext_write(input logic [1:0] drv, input logic [1:0] tmp, input logic [2:0] area);
      drive(4'h0, 1'b1, MRS_SEL_EXT, {6'h00, drv, tmp, area});
   endtask : ext_write

   task automatic mask(input logic m);
      @(posedge ref_clk);
      writeByteMask <= m;
   endtask : mask
endmodule : lcd_ctrl_model
`default_nettype wire

// [verif/tb_lpddr_cmd_decode_ext_mode.sv]
// self-checking bench for the command decoder and extended mode register
// assumes: lcd_pkg compiled first, controller model drives all command pins
`timescale 1ns/1ps
`default_nettype none
module tb_lpddr_cmd_decode_ext_mode;
   import lcd_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic memClkEn, chipSelN, rowStrobeN, colStrobeN, writeEnN, writeByteMask;
   logic [1:0] bankAddr, cmdBank, outputDriveLevel, refreshFraction;
   logic [12:0] addr, rowAddr, baseOpCode;
   logic [10:0] cmdCode;
   logic [9:0] colAddr;
   logic [2:0] partialRefreshArea;
   logic [3:0] refreshBankMask;
   logic cmdValid, autoPrecharge, prechargeAll, writeElemEn, baseModeLoad;
   logic driveReserved, areaReserved, selfRefreshActive, deepPowerDown, cmdTooSoon;
   int n_mismatch = 0;
   int cmp_count = 0;

   always #12.5 ref_clk = ~ref_clk;

   lcd_ctrl_model m (.ref_clk, .memClkEn, .chipSelN, .rowStrobeN, .colStrobeN, .writeEnN, .bankAddr, .addr,
      .writeByteMask);
   lcd_cmd_decoder dut (.ref_clk, .rst, .clkEn, .memClkEn, .chipSelN, .rowStrobeN, .colStrobeN, .writeEnN,
      .bankAddr, .addr, .writeByteMask, .cmdCode, .cmdValid, .cmdBank, .rowAddr, .colAddr, .autoPrecharge,
      .prechargeAll, .writeElemEn, .baseModeLoad, .baseOpCode, .outputDriveLevel, .driveReserved,
      .partialRefreshArea, .areaReserved, .refreshBankMask, .refreshFraction, .selfRefreshActive,
      .deepPowerDown, .cmdTooSoon);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic issue(input logic [3:0] pins, input logic cke, input logic [1:0] ba, input logic [12:0] a);
      m.drive(pins, cke, ba, a);
      m.idle();
      #1;
   endtask : issue

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_ext();
      for (int i = 0; i < 8; i++) begin
         m.ext_write(i[1:0], ~i[1:0], i[2:0]);
         m.idle();
         #1;
         chk({cmdValid, cmdCode}, {1'b1, CMD_MRS});
         chk(outputDriveLevel, i[1:0]);
         chk(driveReserved, i[1:0] == 2'h3);
         chk(partialRefreshArea, i[2:0]);
         chk(areaReserved, i == 3 || i == 4 || i == 7);
      end
      $display("test ext_mode done");
   endtask : t_ext

   task automatic t_hold();
      m.ext_write(2'h1, 2'h0, 3'h5);
      m.idle();
      issue(4'h3, 1'b1, 2'h1, 13'h0444);
      chk({cmdCode, cmdTooSoon}, {CMD_ACT, 1'b0});
      issue(4'h0, 1'b1, MRS_SEL_BASE, 13'h0123);
      chk(baseModeLoad, 1'b1);
      chk(baseOpCode, 13'h0123);
      issue(4'h0, 1'b1, 2'h1, 13'h0000);
      chk(cmdCode, CMD_BAD);
      issue(4'h0, 1'b1, 2'h3, 13'h0000);
      chk(cmdCode, CMD_BAD);
      chk(outputDriveLevel, 2'h1);
      chk(partialRefreshArea, 3'h5);
      $display("test hold done");
   endtask : t_hold

   task automatic t_decode();
      issue(4'h3, 1'b1, 2'h3, 13'h1abc);
      chk(cmdCode, CMD_ACT);
      chk({cmdBank, rowAddr}, {2'h3, 13'h1abc});
      issue(4'h5, 1'b1, 2'h2, 13'h06a5);
      chk(cmdCode, CMD_READ);
      chk({cmdBank, autoPrecharge, colAddr}, {2'h2, 1'b1, 10'h2a5});
      issue(4'h4, 1'b1, 2'h1, 13'h0133);
      chk(cmdCode, CMD_WRITE);
      chk({cmdBank, autoPrecharge, colAddr}, {2'h1, 1'b0, 10'h133});
      issue(4'h5, 1'b1, 2'h1, 13'h0010);
      issue(4'h6, 1'b1, 2'h0, 13'h1fff);
      chk(cmdCode, CMD_STOP);
      issue(4'h7, 1'b1, 2'h0, 13'h0001);
      chk({cmdValid, cmdCode}, {1'b0, CMD_NOP});
      issue(4'hf, 1'b1, 2'h0, 13'h0002);
      chk({cmdValid, cmdCode, rowAddr}, {1'b0, CMD_NOP, 13'h1abc});
      issue(4'h2, 1'b1, 2'h2, 13'h0000);
      chk({cmdCode, prechargeAll, cmdBank}, {CMD_PRE, 1'b0, 2'h2});
      issue(4'h2, 1'b1, 2'h3, 13'h0400);
      chk({cmdCode, prechargeAll, cmdBank}, {CMD_PRE, 1'b1, 2'h0});
      issue(4'h1, 1'b1, 2'h1, 13'h0fff);
      chk({cmdCode, rowAddr, selfRefreshActive}, {CMD_AREF, 13'h1abc, 1'b0});
      $display("test decode done");
   endtask : t_decode

   task automatic t_power();
      logic [2:0] area [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
      logic [5:0] exp [5] = '{6'h3c, 6'h0c, 6'h04, 6'h05, 6'h06};
      for (int i = 0; i < 5; i++) begin
         m.ext_write(2'h0, 2'h0, area[i]);
         m.idle();
         issue(4'h1, 1'b0, 2'h0, 13'h0000);
         chk({cmdCode, selfRefreshActive}, {CMD_SREF, 1'b1});
         chk({refreshBankMask, refreshFraction}, exp[i]);
         @(posedge ref_clk);
         #1;
         chk({selfRefreshActive, refreshBankMask}, 5'h0f);
      end
      issue(4'h6, 1'b0, 2'h0, 13'h0000);
      chk({cmdCode, deepPowerDown}, {CMD_DPD, 1'b1});
      $display("test power done");
   endtask : t_power

   task automatic t_misc();
      for (int b = 0; b < 2; b++) begin
         m.mask(b[0]);
         @(posedge ref_clk);
         #1;
         chk(writeElemEn, !b[0]);
      end
      m.ext_write(2'h0, 2'h0, 3'h0);
      m.drive(4'h3, 1'b1, 2'h0, 13'h0000);
      m.idle();
      #1;
      chk({cmdCode, cmdTooSoon}, {CMD_ACT, 1'b1});
      // frozen clock enable: pins presented now must leave no trace
      @(posedge ref_clk);
      clkEn <= 1'b0;
      issue(4'h3, 1'b1, 2'h1, 13'h0555);
      chk({cmdCode, rowAddr}, {CMD_NOP, 13'h0000});
      @(posedge ref_clk);
      clkEn <= 1'b1;
      $display("test misc done");
   endtask : t_misc

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk({cmdCode, outputDriveLevel, partialRefreshArea, refreshBankMask}, {CMD_NOP, 2'h0, 3'h0, 4'hf});
      t_ext();
      t_hold();
      t_decode();
      t_power();
      t_misc();
      stop_test();
   end

   // whole run needs about 90 cycles
   initial begin
      #(25 * 2000);
      n_mismatch++;
      stop_test();
   end
endmodule : tb_lpddr_cmd_decode_ext_mode
`default_nettype wire
